/* File: fcs_cfg_source.sv */
// Purpose: Configuration data source model
// Assumes: A byte is taken while ready is high
// Notes:   Slow mode offers a byte every other cycle
`timescale 1ns/100ps
`default_nettype none
module fcs_cfg_source #(
   parameter int N = 4
) (
   input  wire logic              i_clk,
   input  wire logic              i_start,
   input  wire logic              i_slow,
   input  wire logic              i_ready,
   output fcs_pkg::fcs_cfg_word_t o_word
);
   logic [7:0] n   = 8'h0;
   logic       act = 1'h0;
   logic       ph  = 1'h0;
   wire logic  v   = act && (!i_slow || ph);
   // Byte words, idle data inverted, last marks the end
   assign o_word = {v, v ? n ^ 8'hA5 : ~(n ^ 8'hA5), v && n == N - 1};
   always @(posedge i_clk) begin
      ph <= ~ph;
      if (i_start) begin
         act <= 1'h1;
         n   <= 8'h0;
      end else if (v && i_ready) begin
         n <= n + 8'h1;
         if (n == N - 1) act <= 1'h0;
      end
   end
endmodule
`default_nettype wire

/* File: fcs_config_sequencer.sv */
// Purpose: Power-on, configuration load, initialization and user-mode
//          sequencing of a volatile programmable logic device
// Assumes: Inputs synchronous to i_core_clk; Avalon-MM register slave
// Notes:   Configuration words arrive already deserialised on the
//          stream port, whichever scheme the loader uses
//
// How it works
// - Power-on reset lasts 100 ms with delay select low, 2 ms if high.
// - User I/O stay high impedance during power-up and configuration.
// - After power-up a full configuration load is needed before user mode.
// - After loading, initialise: reset registers, enable I/O, enter user mode.
// - Pull-up disable input high turns weak pull-ups off, low turns them on during configuration.
// - Reconfiguration request pin forces reload, reinit and return to user.
// - Fast parallel source gives byte words up to 100 MHz.
// - Exactly one of five schemes is used for a configuration.
// - Chain enable out of one device feeds chain enable in of next.
// - PLL counter settings rewrite over a serial chain from logic or pins.
// - Other logic stays in user mode while PLL settings shift.
// - Scan instruction 00 0000 0001 acts like a reconfiguration pulse.
`timescale 1ns/100ps
`default_nettype none

module fcs_config_sequencer #(
   parameter int POR_LONG   = fcs_pkg::POR_LONG_CYC,
   parameter int POR_SHORT  = fcs_pkg::POR_SHORT_CYC,
   parameter int LOAD_WORDS = 16,
   parameter int PLL_BITS   = 32
) (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_reset,
   input  wire logic                  i_power_on_delay_select,
   input  wire logic                  i_config_pullup_disable_n,
   input  wire logic                  i_reconfig_request_n,
   input  wire logic                  i_chain_enable_in_n,
   input  wire fcs_pkg::fcs_scheme_t  i_scheme,
   input  wire fcs_pkg::fcs_cfg_word_t i_cfg_word,
   output logic                       o_cfg_ready,
   output logic                       o_chain_enable_out_n,
   output logic                       o_io_enable,
   output logic                       o_io_pullup_en,
   output logic                       o_init_reset,
   output logic                       o_user_mode,
   input  wire logic                  i_pll_pin_data,
   output logic                       o_pll_scan_data,
   output logic                       o_pll_scan_clk_en,
   output logic                       o_pll_scan_update,
   input  wire logic [3:0]            i_avs_address,
   input  wire logic                  i_avs_read,
   input  wire logic                  i_avs_write,
   input  wire logic [31:0]           i_avs_writedata,
   output logic [31:0]                o_avs_readdata,
   output logic                       o_avs_waitrequest
);
   import fcs_pkg::*;

   // ==========================================================
   // State
   fcs_state_t    state_r, state_nxt;
   logic [31:0]   cnt_r, cnt_nxt;
   logic [31:0]   load_cnt_r;
   fcs_scheme_t   scheme_r;
   fcs_io_ctl_t   io_r;
   logic [31:0]   ctrl_r;
   logic [9:0]    scan_ir_r;
   logic          scan_pulse_r;
   logic          sw_pulse_r;
   logic          rd_ack_r;
   logic          wr_ack_r;
   logic [31:0]   pll_data_r;
   logic [31:0]   pll_shift_r;
   logic [7:0]    pll_cnt_r;
   logic          pll_busy_r;
   logic          pll_src_r;
   logic          pll_upd_r;
   logic          pll_en_r;

   // ==========================================================
   // Functions
   function automatic logic addr_is(
      input logic [3:0] addr,
      input logic [3:0] slot
   );
      return addr == slot;
   endfunction

   function automatic logic [31:0] count_down(
      input logic [31:0] value
   );
      return value - 32'h1;
   endfunction

   function automatic logic in_config(
      input fcs_state_t st
   );
      return st != FCS_ST_USER;
   endfunction

   function automatic logic [31:0] por_load(
      input logic sel
   );
      if (sel) begin
         return 32'(POR_SHORT - 1);
      end
      return 32'(POR_LONG - 1);
   endfunction

   function automatic logic [31:0] read_mux(
      input logic [3:0]  addr,
      input logic [31:0] ctrl_w,
      input logic [31:0] stat_w,
      input logic [31:0] cnt_w,
      input logic [31:0] pctl_w,
      input logic [31:0] pdat_w,
      input logic [31:0] ir_w
   );
      unique case (addr)
         ADDR_CTRL:     return ctrl_w;
         ADDR_STATUS:   return stat_w;
         ADDR_LOAD_CNT: return cnt_w;
         ADDR_PLL_CTRL: return pctl_w;
         ADDR_PLL_DATA: return pdat_w;
         ADDR_SCAN_IR:  return ir_w;
         default:       return 32'h0;
      endcase
   endfunction

   // ==========================================================
   // Decode
   wire   por_done      = (cnt_r == 32'h0);
   wire   scan_reconfig_pulse = scan_pulse_r;
   wire   reconf_req    = !i_reconfig_request_n || scan_reconfig_pulse
                          || sw_pulse_r;
   wire   word_take     = (state_r == FCS_ST_LOAD) && i_cfg_word.valid;
   wire   load_end      = word_take && (i_cfg_word.last
                          || load_cnt_r == 32'(LOAD_WORDS - 1));
   wire   wr_go         = i_avs_write && !wr_ack_r;
   wire   rd_go         = i_avs_read && !rd_ack_r;
   // Writes land only at the edge where waitrequest is low
   wire   wr_take       = i_avs_write && wr_ack_r;
   wire   wr_ctrl       = wr_take && addr_is(i_avs_address, ADDR_CTRL);
   wire   wr_pll_ctrl   = wr_take && addr_is(i_avs_address, ADDR_PLL_CTRL);
   wire   wr_pll_data   = wr_take && addr_is(i_avs_address, ADDR_PLL_DATA);
   wire   wr_scan_ir    = wr_take && addr_is(i_avs_address, ADDR_SCAN_IR);
   wire   pll_start     = wr_pll_ctrl && i_avs_writedata[PLL_START_BIT]
                          && !pll_busy_r;
   wire   pll_bit_in    = pll_src_r ? i_pll_pin_data : pll_shift_r[0];
   wire   [31:0] status_w = {24'h0, pll_busy_r, o_user_mode,
                             io_r.chain_done, 2'h0, state_r};
   wire   [31:0] pll_ctrl_w = {30'h0, pll_src_r, pll_busy_r};
   wire   [31:0] ctrl_rd_w  = {ctrl_r[31:3], scheme_r};
   wire   [31:0] ir_rd_w    = {22'h0, scan_ir_r};
   wire   [31:0] rd_data_w  = read_mux(i_avs_address, ctrl_rd_w, status_w,
                                       load_cnt_r, pll_ctrl_w, pll_data_r,
                                       ir_rd_w);
   wire          por_arm    = (state_r == FCS_ST_POR) && (cnt_r == 32'h0)
                              && !io_r.init_reset;

   // ==========================================================
   // Sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         FCS_ST_POR: begin
            if (por_done) begin
               state_nxt = FCS_ST_WAIT_CHAIN;
            end else begin
               cnt_nxt = count_down(cnt_r);
            end
         end
         FCS_ST_WAIT_CHAIN: begin
            if (!i_chain_enable_in_n) begin
               state_nxt = FCS_ST_LOAD;
            end
         end
         FCS_ST_LOAD: begin
            if (load_end) begin
               state_nxt = FCS_ST_INIT;
               cnt_nxt   = 32'(INIT_CYC - 1);
            end
         end
         FCS_ST_INIT: begin
            if (cnt_r == 32'h0) begin
               state_nxt = FCS_ST_USER;
            end else begin
               cnt_nxt = count_down(cnt_r);
            end
         end
         FCS_ST_USER: begin
            state_nxt = FCS_ST_USER;
         end
      endcase
      if (reconf_req && state_r != FCS_ST_POR) begin
         state_nxt = FCS_ST_WAIT_CHAIN;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_r <= FCS_ST_POR;
         cnt_r   <= 32'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         if (por_arm) begin
            cnt_r   <= por_load(i_power_on_delay_select);
            state_r <= FCS_ST_POR;
         end
      end
   end

   // ==========================================================
   // Load counter and scheme latch
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         load_cnt_r <= 32'h0;
         scheme_r   <= FCS_SCH_MEMDEV;
      end else if (state_r == FCS_ST_WAIT_CHAIN) begin
         load_cnt_r <= 32'h0;
         scheme_r   <= i_scheme;
      end else if (word_take) begin
         load_cnt_r <= load_cnt_r + 32'h1;
      end
   end

   // ==========================================================
   // I/O control
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         io_r <= '{io_enable: 1'b0, io_pullup_en: 1'b0,
                   init_reset: 1'b0, chain_done: 1'b0};
      end else begin
         io_r.init_reset   <= 1'b1;
         io_r.io_enable    <= !in_config(state_nxt);
         io_r.io_pullup_en <= in_config(state_nxt)
                              && !i_config_pullup_disable_n;
         io_r.chain_done   <= (state_nxt == FCS_ST_INIT)
                              || (state_nxt == FCS_ST_USER);
      end
   end

   assign o_io_enable          = io_r.io_enable;
   assign o_io_pullup_en       = io_r.io_pullup_en;
   assign o_init_reset         = (state_r == FCS_ST_INIT);
   assign o_user_mode          = (state_r == FCS_ST_USER);
   assign o_chain_enable_out_n = !io_r.chain_done;
   assign o_cfg_ready          = (state_r == FCS_ST_LOAD);

   // ==========================================================
   // Register slave
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         ctrl_r       <= CTRL_RESET;
         scan_ir_r    <= 10'h000;
         scan_pulse_r <= 1'b0;
         sw_pulse_r   <= 1'b0;
         rd_ack_r     <= 1'b0;
         wr_ack_r     <= 1'b0;
         o_avs_readdata <= 32'h0;
      end else begin
         rd_ack_r     <= rd_go;
         wr_ack_r     <= wr_go;
         scan_pulse_r <= wr_scan_ir
            && i_avs_writedata[SCAN_IR_W-1:0] == SCAN_RECONF_CODE;
         sw_pulse_r   <= wr_ctrl && i_avs_writedata[CTRL_SW_RECONF];
         if (wr_ctrl) begin
            ctrl_r <= i_avs_writedata & 32'h0000_0007;
         end
         if (wr_scan_ir) begin
            scan_ir_r <= i_avs_writedata[SCAN_IR_W-1:0];
         end
         if (rd_go) begin
            o_avs_readdata <= rd_data_w;
         end
      end
   end

   assign o_avs_waitrequest = (i_avs_read && !rd_ack_r)
                              || (i_avs_write && !wr_ack_r);

   // ==========================================================
   // PLL serial reprogramming, independent of the sequencer
   // Clock enable is registered so it frames exactly the valid bits
   wire   pll_last      = pll_busy_r && (pll_cnt_r == 8'h1);
   wire   pll_done      = pll_en_r && !pll_busy_r;

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         pll_data_r  <= 32'h0;
         pll_shift_r <= 32'h0;
         pll_cnt_r   <= 8'h0;
         pll_busy_r  <= 1'b0;
         pll_src_r   <= 1'b0;
         pll_upd_r   <= 1'b0;
         pll_en_r    <= 1'b0;
         o_pll_scan_data <= 1'b0;
      end else begin
         pll_upd_r <= pll_done;
         pll_en_r  <= pll_busy_r;
         if (wr_pll_data && !pll_busy_r) begin
            pll_data_r <= i_avs_writedata;
         end
         if (pll_start) begin
            pll_busy_r  <= 1'b1;
            pll_src_r   <= i_avs_writedata[PLL_SRC_BIT];
            pll_shift_r <= pll_data_r;
            pll_cnt_r   <= 8'(PLL_BITS);
         end else if (pll_busy_r) begin
            o_pll_scan_data <= pll_bit_in;
            pll_shift_r     <= {1'b0, pll_shift_r[31:1]};
            pll_cnt_r       <= pll_cnt_r - 8'h1;
            if (pll_last) begin
               pll_busy_r <= 1'b0;
            end
         end
      end
   end

   assign o_pll_scan_clk_en = pll_en_r;
   assign o_pll_scan_update = pll_upd_r;

endmodule

`default_nettype wire

/* File: fcs_config_sequencer_properties.sv */
// Purpose: Port assertions for the configuration sequencer
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every sequencer instance
`timescale 1ns/100ps
`default_nettype none
module fcs_seq_props (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_config_pullup_disable_n,
   input wire logic i_reconfig_request_n,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_cfg_ready,
   input wire logic o_chain_enable_out_n,
   input wire logic o_io_enable,
   input wire logic o_io_pullup_en,
   input wire logic o_init_reset,
   input wire logic o_user_mode,
   input wire logic o_pll_scan_clk_en,
   input wire logic o_pll_scan_update,
   input wire logic o_avs_waitrequest
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   // ==========================================================
   // Sequences
   sequence s_req; $rose(i_avs_read || i_avs_write); endsequence
   sequence s_ans; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
   sequence s_init; o_init_reset [*8] ##1 o_user_mode; endsequence
   // ==========================================================
   // Properties
   property p_io_off; !o_user_mode && $past(!o_user_mode) |-> !o_io_enable;
   endproperty
   a_io_off: assert property (p_io_off) else $error("io on");
   property p_pull;
      !$past(o_user_mode) && !o_user_mode && !$past(i_reset)
      |-> o_io_pullup_en == !$past(i_config_pullup_disable_n);
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up");
   property p_init; $rose(o_init_reset) |-> s_init; endproperty
   a_init: assert property (p_init) else $error("init");
   property p_user; $rose(o_user_mode) |-> $past(o_init_reset); endproperty
   a_user: assert property (p_user) else $error("user entry");
   property p_chain; o_cfg_ready |-> o_chain_enable_out_n; endproperty
   a_chain: assert property (p_chain) else $error("chain out");
   property p_chain_on; o_user_mode |-> !o_chain_enable_out_n; endproperty
   a_chain_on: assert property (p_chain_on) else $error("chain on");
   property p_reconf; !i_reconfig_request_n && o_user_mode |=> !o_user_mode;
   endproperty
   a_reconf: assert property (p_reconf) else $error("reconfig");
   property p_bus; s_req |-> s_ans; endproperty
   a_bus: assert property (p_bus) else $error("bus answer");
   property p_upd;
      $fell(o_pll_scan_clk_en) |-> o_pll_scan_update ##1 !o_pll_scan_update;
   endproperty
   a_upd: assert property (p_upd) else $error("pll update");
   property p_live;
      o_pll_scan_clk_en && $past(o_user_mode) && i_reconfig_request_n
      |-> o_user_mode;
   endproperty
   a_live: assert property (p_live) else $error("pll live");
endmodule
bind fcs_config_sequencer fcs_seq_props i_props (
   .i_core_clk                (i_core_clk),
   .i_reset                   (i_reset),
   .i_config_pullup_disable_n (i_config_pullup_disable_n),
   .i_reconfig_request_n      (i_reconfig_request_n),
   .i_avs_read                (i_avs_read),
   .i_avs_write               (i_avs_write),
   .o_cfg_ready               (o_cfg_ready),
   .o_chain_enable_out_n      (o_chain_enable_out_n),
   .o_io_enable               (o_io_enable),
   .o_io_pullup_en            (o_io_pullup_en),
   .o_init_reset              (o_init_reset),
   .o_user_mode               (o_user_mode),
   .o_pll_scan_clk_en         (o_pll_scan_clk_en),
   .o_pll_scan_update         (o_pll_scan_update),
   .o_avs_waitrequest         (o_avs_waitrequest)
);
`default_nettype wire

/* File: fcs_config_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the configuration sequencer
// Assumes: Short power-on counts of 20 and 5 cycles
// Notes:   Stops on verdict or watchdog
`timescale 1ns/100ps
`default_nettype none
module fcs_config_sequencer_tb_top;
   import fcs_pkg::*;
   logic          clk = 0, rst = 1, sel = 0, pud = 0, req = 1, cin = 0;
   logic          rd = 0, wr = 0, pin = 0, go = 0, slow = 0;
   logic [3:0]    ad = 4'h0;
   logic [31:0]   wd = 32'h0, q, rq;
   fcs_scheme_t   sch = FCS_SCH_MEMDEV;
   fcs_cfg_word_t cw;
   logic          rdy, cout, ioe, pue, ini, usr, sd, sce, sup, wq;
   int            errors = 0, n_checks = 0;
   always #25 clk = ~clk;
   fcs_config_sequencer #(.POR_LONG(20), .POR_SHORT(5), .LOAD_WORDS(4),
      .PLL_BITS(8)) i_dut (.i_core_clk(clk), .i_reset(rst),
      .i_power_on_delay_select(sel), .i_config_pullup_disable_n(pud),
      .i_reconfig_request_n(req), .i_chain_enable_in_n(cin),
      .i_scheme(sch), .i_cfg_word(cw), .o_cfg_ready(rdy),
      .o_chain_enable_out_n(cout), .o_io_enable(ioe), .o_io_pullup_en(pue),
      .o_init_reset(ini), .o_user_mode(usr), .i_pll_pin_data(pin),
      .o_pll_scan_data(sd), .o_pll_scan_clk_en(sce),
      .o_pll_scan_update(sup), .i_avs_address(ad), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rq),
      .o_avs_waitrequest(wq));
   fcs_cfg_source #(.N(4)) i_src (.i_clk(clk), .i_start(go),
      .i_slow(slow), .i_ready(rdy), .o_word(cw));
   // ==========================================================
   // Helpers
   task automatic chk(input logic [31:0] g, e, input string m);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic conclude();
      if (errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      rd <= !w;
      wr <= w;
      ad <= a;
      wd <= d;
      do @(posedge clk); while (wq !== 1'h0 && ++k < 50);
      q = rq;
      rd <= 1'h0;
      wr <= 1'h0;
      chk(k < 50, 1, "bus timeout");
      @(posedge clk);
   endtask
   task automatic wt(input logic v);
      int k;
      k = 0;
      do @(negedge clk); while (usr !== v && ++k < 300);
      chk(usr, v, "user mode");
      @(posedge clk);
   endtask
   // ==========================================================
   // Scenarios
   task automatic por(input logic s, output int n);
      rst <= 1'h1;
      sel <= s;
      cyc(8);
      rst <= 1'h0;
      n = 0;
      do @(negedge clk); while (rdy !== 1'h1 && ++n < 300);
      chk(ioe, 0, "io during config");
      chk(pue, !pud, "pull-up");
      @(posedge clk);
   endtask
   task automatic ld(input logic s);
      slow <= s;
      go <= 1'h1;
      cyc(1);
      go <= 1'h0;
      wt(1'h1);
      cyc(2);
      chk(cout, 0, "chain out");
      chk(ioe, 1, "io on");
   endtask
   task automatic trig(input int k);
      if (k == 0) begin
         req <= 1'h0;
         cyc(2);
         req <= 1'h1;
      end else if (k == 1) bus(1, ADDR_CTRL, 32'h10 | 32'(sch));
      else bus(1, ADDR_SCAN_IR, 32'(SCAN_RECONF_CODE));
      cyc(3);
      chk(usr, 0, "reconfig");
      chk(ioe, 0, "io off");
   endtask
   task automatic pll(input logic src);
      int n;
      int u;
      n = 0;
      u = 0;
      pin <= src;
      bus(1, ADDR_PLL_DATA, 32'h0000_00B4);
      fork
         bus(1, ADDR_PLL_CTRL, {30'h0, src, 1'h1});
         repeat (40) begin
            @(negedge clk);
            if (sce === 1'h1) begin
               chk(sd, src | 1'(8'hB4 >> n), "scan bit");
               n++;
            end
            if (sup === 1'h1) u++;
            chk(usr, 1, "user during pll");
         end
      join
      chk(n, 8, "scan length");
      chk(u, 1, "update pulse");
      @(posedge clk);
   endtask
   initial begin
      int a;
      int b;
      por(1'h0, a);
      cyc(20);
      chk(usr, 0, "no load no user");
      ld(1'h0);
      pud <= 1'h1;
      por(1'h1, b);
      chk(a - b, 15, "por delay");
      ld(1'h1);
      for (int s = 0; s < 5; s++) begin
         sch <= fcs_scheme_t'(s);
         trig(s % 3);
         ld(s[0]);
         bus(0, ADDR_CTRL, 32'h0);
         chk(q[2:0], s[2:0], "scheme");
      end
      cin <= 1'h1;
      trig(0);
      cyc(30);
      chk(rdy, 0, "held by chain");
      chk(cout, 1, "chain out idle");
      cin <= 1'h0;
      ld(1'h0);
      bus(1, ADDR_SCAN_IR, 32'h00D);
      cyc(3);
      chk(usr, 1, "other scan code");
      bus(0, ADDR_STATUS, 32'h0);
      chk(q[6], 1, "status user");
      bus(0, 4'hE, 32'h0);
      chk(q, 0, "unmapped read");
      bus(0, ADDR_LOAD_CNT, 32'h0);
      chk(q, 4, "word count");
      pll(1'h0);
      pll(1'h1);
      conclude();
   end
   initial begin
      cyc(6000);
      errors++;
      conclude();
   end
endmodule
`default_nettype wire

/* File: fcs_pkg.sv */
// Purpose: Shared constants and types for the configuration sequencer
// Assumes: 20 MHz core clock
// Notes:   Power-on counts derive from the clock period; INIT_CYC is a fixed cycle count
package fcs_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int POR_LONG_MS   = 100;
   localparam int POR_SHORT_MS  = 2;
   localparam int POR_LONG_CYC  = POR_LONG_MS * 1000000 / CLK_PERIOD_NS;
   localparam int POR_SHORT_CYC = POR_SHORT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int INIT_CYC      = 8;

   // ==========================================================
   // Register map (word addresses, register index in address bits)
   localparam logic [3:0] ADDR_CTRL     = 4'h0;
   localparam logic [3:0] ADDR_STATUS   = 4'h1;
   localparam logic [3:0] ADDR_LOAD_CNT = 4'h2;
   localparam logic [3:0] ADDR_PLL_CTRL = 4'h3;
   localparam logic [3:0] ADDR_PLL_DATA = 4'h4;
   localparam logic [3:0] ADDR_SCAN_IR  = 4'h5;

   // Control fields
   localparam int CTRL_SCHEME_LSB = 0;
   localparam int CTRL_SW_RECONF  = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int PLL_START_BIT   = 0;
   localparam int PLL_SRC_BIT     = 1;

   // Scan instruction that emulates a reconfiguration pulse
   localparam logic [9:0] SCAN_RECONF_CODE = 10'h001;
   localparam int         SCAN_IR_W        = 10;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      FCS_SCH_MEMDEV,
      FCS_SCH_SERIAL,
      FCS_SCH_PAR_ASYNC,
      FCS_SCH_PAR_FAST,
      FCS_SCH_SCAN
   } fcs_scheme_t;

   typedef enum logic [2:0] {
      FCS_ST_POR,
      FCS_ST_WAIT_CHAIN,
      FCS_ST_LOAD,
      FCS_ST_INIT,
      FCS_ST_USER
   } fcs_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } fcs_cfg_word_t;

   typedef struct packed {
      logic io_enable;
      logic io_pullup_en;
      logic init_reset;
      logic chain_done;
   } fcs_io_ctl_t;

endpackage
